// File: lftd_meas_model.sv
// lftd_meas_model: rms front end and recording controller stand-in
// assumes one clock; the bench calls its send tasks one at a time
`timescale 1ns/1ps
module lftd_meas_model
    import lftd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // measurements toward the block
    output logic rms_valid,
    output logic [6:0][MEAS_W-1:0] rv,
    output logic xdcr_valid,
    output logic [2:0] xdcr_chan,
    output logic signed [15:0] xdcr_sample,
    // recording side
    input wire logic capture_start,
    input wire logic [EV_W-1:0] trigger_cause,
    input wire logic xdcr_out_valid,
    input wire logic [2:0] xdcr_out_chan,
    input wire logic signed [15:0] xdcr_out_value
);
    int cap_cnt;
    int out_cnt;
    logic [EV_W-1:0] last_cause;
    logic [2:0] last_chan;
    logic signed [15:0] last_value;
    initial begin
        rms_valid = 1'b0;
        rv = '0;
        xdcr_valid = 1'b0;
        xdcr_chan = 3'h0;
        xdcr_sample = 16'sh0000;
    end
    // values are inverted once valid drops so stale data never looks good
    task send_rms(input logic [6:0][MEAS_W-1:0] v);
        @(posedge clk);
        rms_valid <= 1'b1;
        rv <= v;
        @(posedge clk);
        rms_valid <= 1'b0;
        rv <= ~v;
    endtask
    task send_xdcr(input logic [2:0] c, input logic [15:0] s);
        @(posedge clk);
        xdcr_valid <= 1'b1;
        xdcr_chan <= c;
        xdcr_sample <= s;
        @(posedge clk);
        xdcr_valid <= 1'b0;
        xdcr_sample <= ~s;
    endtask
    // recorder counts every trigger and every scaled reading
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt <= 0;
            out_cnt <= 0;
        end else begin
            if (capture_start) begin
                cap_cnt <= cap_cnt + 1;
                last_cause <= trigger_cause;
            end
            if (xdcr_out_valid) begin
                out_cnt <= out_cnt + 1;
                last_chan <= xdcr_out_chan;
                last_value <= xdcr_out_value;
            end
        end
    end
endmodule

// File: lftd_oc_det.sv
// lftd_oc_det: pickup and dropout detector for a group of currents
// assumes levels are held stable while valid is high
`timescale 1ns/1ps
module lftd_oc_det
    import lftd_pkg::*;
#(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels, settings and pulses
    lftd_oc_if.det oc
);
    logic [N-1:0] above;
    logic [N-1:0] below90;
    lftd_oc_state_type state_reg;
    lftd_oc_state_type state_next;
    logic pu_reg;
    logic do_reg;
    logic [19:0] pick_x9;

    // pickup scaled once, shared by every channel
    assign pick_x9 = 20'(oc.pickup) * 20'(DO_NUM);

    // per channel comparators
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            assign above[g] = oc.level[g] > oc.pickup;
            assign below90[g] = 20'(oc.level[g]) * 20'(DO_DEN) < pick_x9;
        end
    endgenerate

    // any channel picks the group up, all must fall to drop it out
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OC_IDLE: if (oc.valid && |above) state_next = OC_PICKED;
            OC_PICKED: if (oc.valid && &below90) state_next = OC_IDLE;
            default: state_next = OC_IDLE;
        endcase
    end

    // pulses only on state edges, gated by the selects
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= OC_IDLE;
            pu_reg <= 1'b0;
            do_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pu_reg <= (state_reg == OC_IDLE) && (state_next == OC_PICKED)
                && oc.oc_sel;
            do_reg <= (state_reg == OC_PICKED) && (state_next == OC_IDLE)
                && oc.oc_sel && oc.do_sel;
        end
    end

    assign oc.pickup_pulse = pu_reg;
    assign oc.dropout_pulse = do_reg;
    assign oc.picked = state_reg;
endmodule

// File: lftd_oc_if.sv
// lftd_oc_if: ties one overcurrent detector to the top module
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface lftd_oc_if #(
    parameter int N = 3
);
    import lftd_pkg::*;
    logic valid;
    logic [N-1:0][MEAS_W-1:0] level;
    logic [MEAS_W-1:0] pickup;
    logic oc_sel;
    logic do_sel;
    logic pickup_pulse;
    logic dropout_pulse;
    logic picked;
    // top drives settings and levels, detector answers with pulses
    modport src (output valid, level, pickup, oc_sel, do_sel,
        input pickup_pulse, dropout_pulse, picked);
    modport det (input valid, level, pickup, oc_sel, do_sel,
        output pickup_pulse, dropout_pulse, picked);
endinterface

// File: lftd_pkg.sv
// lftd_pkg: constants, types and helpers of the line fault trigger detector
// assumes a single clock; rms and transducer words arrive in that domain
package lftd_pkg;
    // data widths and channel count
    localparam int MEAS_W = 16;
    localparam int NUM_XDCR = 6;
    localparam int EV_W = 5;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PHASE_PU = 12'h004;
    localparam logic [11:0] OFS_GROUND_PU = 12'h008;
    localparam logic [11:0] OFS_UV_LEVEL = 12'h00c;
    localparam logic [11:0] OFS_INT_STATUS = 12'h010;
    localparam logic [11:0] OFS_INT_MASK = 12'h014;
    localparam logic [11:0] OFS_LIVE = 12'h018;
    // transducer page: paddr[11:8], channel in paddr[6:4], word in [3:2]
    localparam logic [3:0] XDCR_PAGE = 4'h1;
    localparam logic [1:0] XW_RANGE = 2'h0;
    localparam logic [1:0] XW_FULL = 2'h1;
    localparam logic [1:0] XW_ZERO = 2'h2;
    localparam logic [1:0] XW_READ = 2'h3;
    // control bit positions and reset value
    localparam int CTRL_OC = 0;
    localparam int CTRL_DO = 1;
    localparam int CTRL_UV = 2;
    localparam int CTRL_XB = 3;
    localparam logic [3:0] CTRL_RESET = 4'h5;
    // event bit positions in status, mask and cause
    localparam int EV_PH_PU = 0;
    localparam int EV_GR_PU = 1;
    localparam int EV_PH_DO = 2;
    localparam int EV_GR_DO = 3;
    localparam int EV_UV = 4;
    // currents in hundredths of nominal, voltages in tenths of a volt
    localparam logic [15:0] PH_PU_MIN = 16'h0028;
    localparam logic [15:0] PH_PU_MAX = 16'h07d0;
    localparam logic [15:0] PH_PU_RESET = 16'h00c8;
    localparam logic [15:0] GR_PU_MIN = 16'h000a;
    localparam logic [15:0] GR_PU_MAX = 16'h07d0;
    localparam logic [15:0] GR_PU_RESET = 16'h0014;
    localparam logic [15:0] UV_MIN = 16'h0064;
    localparam logic [15:0] UV_MAX = 16'h02bc;
    localparam logic [15:0] UV_RESET = 16'h01f4;
    // dropout when level * DO_DEN < pickup * DO_NUM
    localparam logic [3:0] DO_NUM = 4'h9;
    localparam logic [3:0] DO_DEN = 4'ha;
    // scale settings limited to plus or minus this
    localparam logic signed [15:0] SCALE_LIM = 16'sh2710;
    // transducer samples: millivolts for voltage ranges, microamps else
    typedef enum logic [2:0] {
        RNG_BI10 = 3'b000, RNG_UNI10 = 3'b001, RNG_BI5 = 3'b010,
        RNG_UNI5 = 3'b011, RNG_MA1 = 3'b100, RNG_MA20 = 3'b101
    } lftd_range_type;
    // overcurrent detector states
    typedef enum logic {
        OC_IDLE = 1'b0,
        OC_PICKED = 1'b1
    } lftd_oc_state_type;

    // input value at the bottom of a range
    function automatic logic signed [15:0] lftd_range_min(logic [2:0] r);
        case (r)
            RNG_BI10: lftd_range_min = -16'sh2710;
            RNG_BI5: lftd_range_min = -16'sh1388;
            RNG_MA20: lftd_range_min = 16'sh0fa0;
            default: lftd_range_min = 16'sh0000;
        endcase
    endfunction

    // width of a range, top minus bottom
    function automatic logic signed [15:0] lftd_range_span(logic [2:0] r);
        case (r)
            RNG_BI10: lftd_range_span = 16'sh4e20;
            RNG_UNI10, RNG_BI5: lftd_range_span = 16'sh2710;
            RNG_UNI5: lftd_range_span = 16'sh1388;
            RNG_MA1: lftd_range_span = 16'sh03e8;
            default: lftd_range_span = 16'sh3e80;
        endcase
    endfunction

    // bounded settings: out-of-range writes saturate
    function automatic logic [15:0] lftd_clamp(logic [15:0] v,
        logic [15:0] lo, logic [15:0] hi);
        lftd_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic signed [15:0] lftd_sclamp(logic signed [15:0] v);
        lftd_sclamp = (v < -SCALE_LIM) ? -SCALE_LIM :
                      ((v > SCALE_LIM) ? SCALE_LIM : v);
    endfunction
endpackage

// File: lftd_top.sv
// lftd_top: trigger decision, transducer scaling and apb register file
// assumes rms results and transducer samples come from logic on clk
`timescale 1ns/1ps

module lftd_top
    import lftd_pkg::*;
#(
    parameter int NX = NUM_XDCR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // rms results, one set per valid pulse
    input wire logic rms_valid,
    input wire logic [MEAS_W-1:0] rms_ia,
    input wire logic [MEAS_W-1:0] rms_ib,
    input wire logic [MEAS_W-1:0] rms_ic,
    input wire logic [MEAS_W-1:0] rms_ig,
    input wire logic [MEAS_W-1:0] rms_va,
    input wire logic [MEAS_W-1:0] rms_vb,
    input wire logic [MEAS_W-1:0] rms_vc,
    // digitized transducer samples
    input wire logic xdcr_valid,
    input wire logic [2:0] xdcr_chan,
    input wire logic signed [15:0] xdcr_sample,
    // recording controller
    output logic capture_start,
    output logic report_start,
    output logic [EV_W-1:0] trigger_cause,
    // scaled transducer readings and digitizer enable
    output logic xdcr_enable,
    output logic xdcr_out_valid,
    output logic [2:0] xdcr_out_chan,
    output logic signed [15:0] xdcr_out_value,
    // interrupt
    output logic irq
);
    // settings and status
    logic [3:0] ctrl_reg;
    logic [15:0] phase_pu_reg;
    logic [15:0] ground_pu_reg;
    logic [15:0] uv_level_reg;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] status_next;
    logic [EV_W-1:0] mask_reg;
    logic [15:0] trig_count_reg;
    logic uv_state_reg;
    logic uv_pulse_reg;
    // transducer settings and readings
    logic [2:0] range_reg [NX];
    logic signed [15:0] full_reg [NX];
    logic signed [15:0] zero_reg [NX];
    logic signed [15:0] reading_reg [NX];
    // outputs
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic capture_reg;
    logic report_reg;
    logic [EV_W-1:0] cause_reg;
    logic xo_valid_reg;
    logic [2:0] xo_chan_reg;
    logic signed [15:0] xo_value_reg;
    logic irq_reg;

    // overcurrent detectors for phase and ground groups
    lftd_oc_if #(.N(3)) ph_bus ();
    lftd_oc_if #(.N(1)) gr_bus ();

    assign ph_bus.valid = rms_valid;
    assign ph_bus.level = {rms_ic, rms_ib, rms_ia};
    assign ph_bus.pickup = phase_pu_reg;
    assign ph_bus.oc_sel = ctrl_reg[CTRL_OC];
    assign ph_bus.do_sel = ctrl_reg[CTRL_DO];
    assign gr_bus.valid = rms_valid;
    assign gr_bus.level = rms_ig;
    assign gr_bus.pickup = ground_pu_reg;
    assign gr_bus.oc_sel = ctrl_reg[CTRL_OC];
    assign gr_bus.do_sel = ctrl_reg[CTRL_DO];

    lftd_oc_det #(.N(3)) u_phase (
        .clk(clk),
        .rst_n(rst_n),
        .oc(ph_bus)
    );

    lftd_oc_det #(.N(1)) u_ground (
        .clk(clk),
        .rst_n(rst_n),
        .oc(gr_bus)
    );

    // undervoltage: any phase below the level
    logic uv_below;
    assign uv_below = (rms_va < uv_level_reg) || (rms_vb < uv_level_reg)
        || (rms_vc < uv_level_reg);

    // state follows voltage always, so enabling later gives no stale edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_state_reg <= 1'b0;
            uv_pulse_reg <= 1'b0;
        end else begin
            if (rms_valid) uv_state_reg <= uv_below;
            uv_pulse_reg <= rms_valid && uv_below && !uv_state_reg
                && ctrl_reg[CTRL_UV];
        end
    end

    // gathered trigger events
    logic [EV_W-1:0] ev;
    assign ev[EV_PH_PU] = ph_bus.pickup_pulse;
    assign ev[EV_GR_PU] = gr_bus.pickup_pulse;
    assign ev[EV_PH_DO] = ph_bus.dropout_pulse;
    assign ev[EV_GR_DO] = gr_bus.dropout_pulse;
    assign ev[EV_UV] = uv_pulse_reg;

    // one pulse to recording and report for every trigger
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_reg <= 1'b0;
            report_reg <= 1'b0;
            cause_reg <= '0;
            trig_count_reg <= 16'h0000;
        end else begin
            capture_reg <= |ev;
            report_reg <= |ev;
            cause_reg <= ev;
            if (|ev) trig_count_reg <= trig_count_reg + 16'h0001;
        end
    end

    // transducer scaling, out-of-range channels are dropped
    logic xs_ok;
    logic [2:0] xs_idx;
    logic [2:0] xs_code;
    logic signed [15:0] xs_min;
    logic signed [15:0] xs_span;
    logic signed [15:0] xs_top;
    logic signed [15:0] xs_clip;
    logic signed [16:0] xs_off;
    logic signed [16:0] xs_dif;
    logic signed [33:0] xs_prod;
    logic signed [33:0] xs_quot;
    logic signed [15:0] xs_value;

    assign xs_ok = xdcr_valid && ctrl_reg[CTRL_XB]
        && (xdcr_chan < 3'(NX));
    assign xs_idx = (xdcr_chan < 3'(NX)) ? xdcr_chan : 3'h0;
    assign xs_code = range_reg[xs_idx];
    assign xs_min = lftd_range_min(xs_code);
    assign xs_span = lftd_range_span(xs_code);
    assign xs_top = xs_min + xs_span;
    // inputs beyond the range saturate rather than extrapolate
    assign xs_clip = (xdcr_sample < xs_min) ? xs_min :
        ((xdcr_sample > xs_top) ? xs_top : xdcr_sample);
    assign xs_off = 17'(xs_clip) - 17'(xs_min);
    assign xs_dif = 17'(full_reg[xs_idx]) - 17'(zero_reg[xs_idx]);
    assign xs_prod = 34'(xs_off) * 34'(xs_dif);
    // one cycle divider; slow at 20 MHz but needs no reciprocal table
    assign xs_quot = xs_prod / 34'(xs_span);
    assign xs_value = 16'(34'(zero_reg[xs_idx]) + xs_quot);

    // apb decode
    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [11:0] wa;
    logic [2:0] xa_chan;
    logic xa_hit;
    logic mapped;
    logic [31:0] rd_xdcr;
    logic [31:0] rd_data;
    logic [15:0] wd16;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign wa = {paddr[11:2], 2'b00};
    assign wd16 = pwdata[15:0];
    assign xa_chan = paddr[6:4];
    assign xa_hit = (paddr[11:8] == XDCR_PAGE) && !paddr[7]
        && (xa_chan < 3'(NX));
    assign mapped = xa_hit || (wa == OFS_CTRL) || (wa == OFS_PHASE_PU)
        || (wa == OFS_GROUND_PU) || (wa == OFS_UV_LEVEL)
        || (wa == OFS_INT_STATUS) || (wa == OFS_INT_MASK)
        || (wa == OFS_LIVE);

    // read selection; unmapped words read zero
    logic [2:0] xa_idx;
    assign xa_idx = xa_hit ? xa_chan : 3'h0;
    assign rd_xdcr =
        (paddr[3:2] == XW_RANGE) ? {29'h0, range_reg[xa_idx]} :
        (paddr[3:2] == XW_FULL) ? 32'(full_reg[xa_idx]) :
        (paddr[3:2] == XW_ZERO) ? 32'(zero_reg[xa_idx]) :
        32'(reading_reg[xa_idx]);
    assign rd_data =
        xa_hit ? rd_xdcr :
        (wa == OFS_CTRL) ? {28'h0, ctrl_reg} :
        (wa == OFS_PHASE_PU) ? {16'h0, phase_pu_reg} :
        (wa == OFS_GROUND_PU) ? {16'h0, ground_pu_reg} :
        (wa == OFS_UV_LEVEL) ? {16'h0, uv_level_reg} :
        (wa == OFS_INT_STATUS) ? {27'h0, status_reg} :
        (wa == OFS_INT_MASK) ? {27'h0, mask_reg} :
        (wa == OFS_LIVE) ? {trig_count_reg, 13'h0, uv_state_reg,
            gr_bus.picked, ph_bus.picked} : 32'h0000_0000;

    // read data is sampled in setup, so the access phase is one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup) prdata_reg <= rd_data;
        end
    end

    // read clears only the bits the reader saw; new events win
    logic [EV_W-1:0] st_clr;
    assign st_clr = (rd_en && (wa == OFS_INT_STATUS)) ?
        prdata_reg[EV_W-1:0] : '0;
    assign status_next = (status_reg & ~st_clr) | ev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // trigger settings; pickups and uv level saturated to their legal ranges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            phase_pu_reg <= PH_PU_RESET;
            ground_pu_reg <= GR_PU_RESET;
            uv_level_reg <= UV_RESET;
            mask_reg <= '0;
        end else if (wr_en) begin
            if (wa == OFS_CTRL) ctrl_reg <= pwdata[3:0];
            if (wa == OFS_PHASE_PU)
                phase_pu_reg <= lftd_clamp(wd16, PH_PU_MIN, PH_PU_MAX);
            if (wa == OFS_GROUND_PU)
                ground_pu_reg <= lftd_clamp(wd16, GR_PU_MIN, GR_PU_MAX);
            if (wa == OFS_UV_LEVEL)
                uv_level_reg <= lftd_clamp(wd16, UV_MIN, UV_MAX);
            if (wa == OFS_INT_MASK) mask_reg <= pwdata[EV_W-1:0];
        end
    end

    // per channel settings and readings
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NX; i++) begin
                range_reg[i] <= 3'h0;
                full_reg[i] <= 16'sh0000;
                zero_reg[i] <= 16'sh0000;
                reading_reg[i] <= 16'sh0000;
            end
        end else begin
            if (wr_en && xa_hit) begin
                // codes above five are ignored, old range stays
                if (paddr[3:2] == XW_RANGE && pwdata[2:0] <= 3'h5)
                    range_reg[xa_chan] <= pwdata[2:0];
                if (paddr[3:2] == XW_FULL)
                    full_reg[xa_chan] <= lftd_sclamp(wd16);
                if (paddr[3:2] == XW_ZERO)
                    zero_reg[xa_chan] <= lftd_sclamp(wd16);
            end
            if (xs_ok) reading_reg[xs_idx] <= xs_value;
        end
    end

    // streamed reading for the recorder
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xo_valid_reg <= 1'b0;
            xo_chan_reg <= 3'h0;
            xo_value_reg <= 16'sh0000;
        end else begin
            xo_valid_reg <= xs_ok;
            if (xs_ok) begin
                xo_chan_reg <= xs_idx;
                xo_value_reg <= xs_value;
            end
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign capture_start = capture_reg;
    assign report_start = report_reg;
    assign trigger_cause = cause_reg;
    assign xdcr_enable = ctrl_reg[CTRL_XB];
    assign xdcr_out_valid = xo_valid_reg;
    assign xdcr_out_chan = xo_chan_reg;
    assign xdcr_out_value = xo_value_reg;
    assign irq = irq_reg;
endmodule

// File: lftd_top_sva.sv
// lftd_top_chk: port-level checks of the trigger detector
// assumes it is bound onto lftd_top with one clock and reset
`timescale 1ns/1ps
module lftd_top_chk
    import lftd_pkg::*;
#(
    parameter int NX = NUM_XDCR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // trigger path
    input wire logic rms_valid,
    input wire logic capture_start,
    input wire logic report_start,
    input wire logic [EV_W-1:0] trigger_cause,
    // transducer path
    input wire logic xdcr_valid,
    input wire logic [2:0] xdcr_chan,
    input wire logic xdcr_enable,
    input wire logic xdcr_out_valid,
    input wire logic [2:0] xdcr_out_chan
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // apb answers in the first access cycle, for one cycle only
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // capture and report always travel together with a cause
    a_cap_report_pair: assert property (capture_start == report_start)
        else $error("capture and report differ");
    a_cause_present: assert property (capture_start |-> trigger_cause != '0)
        else $error("trigger without cause");
    a_cap_latency: assert property (capture_start |-> $past(rms_valid, 2))
        else $error("trigger not two cycles after rms set");
    // scaled readings only from accepted samples, channel kept
    a_xdcr_gate: assert property (xdcr_out_valid |-> $past(xdcr_valid)
        && $past(xdcr_enable) && $past(xdcr_chan) < NX)
        else $error("transducer output without accepted sample");
    a_xdcr_chan_echo: assert property (xdcr_out_valid |->
        xdcr_out_chan == $past(xdcr_chan))
        else $error("transducer output on wrong channel");
endmodule

bind lftd_top lftd_top_chk #(.NX(NX)) u_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .rms_valid(rms_valid), .capture_start(capture_start),
    .report_start(report_start), .trigger_cause(trigger_cause),
    .xdcr_valid(xdcr_valid), .xdcr_chan(xdcr_chan),
    .xdcr_enable(xdcr_enable), .xdcr_out_valid(xdcr_out_valid),
    .xdcr_out_chan(xdcr_out_chan));

// File: lftd_top_tb.sv
// lftd_top_tb: register and trigger sequences against the detector
// assumes the measurement model stands at the rms and recorder side
`timescale 1ns/1ps
module lftd_top_tb;
    import lftd_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rms_valid, xdcr_valid, cap, rep, xen, ov, irq;
    logic [6:0][MEAS_W-1:0] rv;
    logic [2:0] xch, och;
    logic signed [15:0] xs, oval;
    logic [EV_W-1:0] cause;
    int errors, checks_done, cycles, ncap;
    int mins[6] = '{-10000, 0, -5000, 0, 0, 4000};
    int spans[6] = '{20000, 10000, 10000, 5000, 1000, 16000};
    lftd_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rms_valid(rms_valid),
        .rms_ia(rv[0]), .rms_ib(rv[1]), .rms_ic(rv[2]), .rms_ig(rv[3]),
        .rms_va(rv[4]), .rms_vb(rv[5]), .rms_vc(rv[6]),
        .xdcr_valid(xdcr_valid), .xdcr_chan(xch), .xdcr_sample(xs),
        .capture_start(cap), .report_start(rep), .trigger_cause(cause),
        .xdcr_enable(xen), .xdcr_out_valid(ov), .xdcr_out_chan(och),
        .xdcr_out_value(oval), .irq(irq));
    lftd_meas_model m (.clk(clk), .rst_n(rst_n), .rms_valid(rms_valid),
        .rv(rv), .xdcr_valid(xdcr_valid), .xdcr_chan(xch),
        .xdcr_sample(xs), .capture_start(cap), .trigger_cause(cause),
        .xdcr_out_valid(ov), .xdcr_out_chan(och), .xdcr_out_value(oval));
    // 50 ns clock and a hang limit far above the expected run
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end
    task test_done();
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // send one rms set, phase a current, ground current, phase b volts
    task trig(input logic [15:0] i, g, v, input logic [4:0] c);
        m.send_rms({16'h0258, v, 16'h0258, g, 16'h0000, 16'h0000, i});
        repeat (4) @(posedge clk);
        if (c != 5'h00) ncap++;
        chk("captures", ncap, m.cap_cnt);
        if (c != 5'h00) chk("cause", c, m.last_cause);
    endtask
    function automatic logic [11:0] xa(input int n, input logic [1:0] w);
        return {XDCR_PAGE, 1'b0, n[2:0], w, 2'b00};
    endfunction
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdc("ctrl", OFS_CTRL, 32'h5);
        rdc("phase pickup", OFS_PHASE_PU, 32'hc8);
        rdc("ground pickup", OFS_GROUND_PU, 32'h14);
        rdc("uv level", OFS_UV_LEVEL, 32'h1f4);
        rdc("mask", OFS_INT_MASK, 32'h0);
        apb(1'b1, OFS_INT_MASK, 32'h1f);
        apb(1'b1, OFS_CTRL, 32'h3);
        trig(16'd200, 16'd0, 16'd600, 5'h00);
        trig(16'd201, 16'd0, 16'd600, 5'h01);
        chk("irq", 32'h1, irq);
        rdc("status", OFS_INT_STATUS, 32'h1);
        rdc("status", OFS_INT_STATUS, 32'h0);
        chk("irq", 32'h0, irq);
        trig(16'd180, 16'd0, 16'd600, 5'h00);
        trig(16'd179, 16'd0, 16'd600, 5'h04);
        trig(16'd0, 16'd21, 16'd600, 5'h02);
        trig(16'd0, 16'd17, 16'd600, 5'h08);
        rdc("status", OFS_INT_STATUS, 32'he);
        // masked event sets status but leaves irq low
        apb(1'b1, OFS_INT_MASK, 32'h0);
        trig(16'd0, 16'd21, 16'd600, 5'h02);
        chk("irq", 32'h0, irq);
        rdc("status", OFS_INT_STATUS, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h2);
        trig(16'd500, 16'd500, 16'd600, 5'h00);
        trig(16'd0, 16'd0, 16'd600, 5'h00);
        apb(1'b1, OFS_CTRL, 32'h4);
        trig(16'd0, 16'd0, 16'd499, 5'h10);
        trig(16'd0, 16'd0, 16'd499, 5'h00);
        trig(16'd0, 16'd0, 16'd600, 5'h00);
        apb(1'b1, OFS_CTRL, 32'h0);
        trig(16'd0, 16'd0, 16'd499, 5'h00);
        rdc("live", OFS_LIVE, 32'h0006_0004);
        apb(1'b1, OFS_UV_LEVEL, 32'd50);
        rdc("uv level", OFS_UV_LEVEL, 32'h64);
        apb(1'b1, OFS_UV_LEVEL, 32'd800);
        rdc("uv level", OFS_UV_LEVEL, 32'h2bc);
        // samples are dropped while the board is absent
        chk("board enable", 32'h0, xen);
        m.send_xdcr(3'h0, 16'h0000);
        repeat (3) @(posedge clk);
        chk("readings", 32'h0, m.out_cnt);
        apb(1'b1, OFS_CTRL, 32'h8);
        @(posedge clk);
        chk("board enable", 32'h1, xen);
        // a quarter of each span maps to zero plus a quarter of full minus zero
        for (int n = 0; n < 6; n++) begin
            apb(1'b1, xa(n, XW_RANGE), n);
            apb(1'b1, xa(n, XW_FULL), 32'd2100);
            apb(1'b1, xa(n, XW_ZERO), 32'd100);
            rdc("range", xa(n, XW_RANGE), n);
            m.send_xdcr(n[2:0], 16'(mins[n] + spans[n] / 4));
            repeat (3) @(posedge clk);
            chk("xdcr chan", n, m.last_chan);
            chk("xdcr value", 32'd600, m.last_value);
            rdc("reading", xa(n, XW_READ), 32'd600);
        end
        apb(1'b1, xa(0, XW_RANGE), 32'h6);
        rdc("range", xa(0, XW_RANGE), 32'h0);
        apb(1'b1, xa(0, XW_FULL), 32'd12000);
        rdc("full", xa(0, XW_FULL), 32'h2710);
        apb(1'b1, xa(0, XW_ZERO), 32'hffffb1e0);
        rdc("zero", xa(0, XW_ZERO), 32'hffffd8f0);
        rdc("unmapped", 12'h01c, 32'h0);
        chk("slverr", 32'h1, err);
        rdc("chan six", xa(6, XW_RANGE), 32'h0);
        chk("slverr", 32'h1, err);
        test_done();
    end
endmodule
